// file: logic/freefall_motion_threshold_detect.v
// freefall/motion threshold registers, per-sample comparison and debounce.
// assumes one-cycle sample_tick_in pulses at the output data rate, samples
// stable while the tick is high, and a byte register port driven synchronously.
//
// Behaviour
// - with clear mode set, the debounce counter goes to zero on every sample without the condition.
// - with clear mode clear, the counter drops by one per sample without the condition, stopping at zero.
// - the clear mode acts the same with shared or per-axis thresholds.
// - the shared threshold is 7 unsigned low bits of its register at 63 mg per count, reset zero.
// - with per-axis enable clear, all three axes compare with the shared 0..127 threshold.
// - with per-axis enable set, the shared threshold is ignored and each axis uses its own.
// - each per-axis threshold is 13 unsigned bits built from a high and a low register.
// - each high register holds threshold bits 12..6 low, and X high bit 7 is the per-axis enable.
// - with event logic zero, a low-g event needs every enabled axis below its threshold.
// - with event logic one, a high-g event needs at least one enabled axis above its threshold.
// - the event flag is set once the counter reaches the programmed debounce count.
// - the counter saturates at the programmed debounce count.
`timescale 1ns/1ns
`default_nettype none
`include "ffmt_regs.vh"

module freefall_motion_threshold_detect #(
  parameter SAMPLE_W = `FFMT_SAMPLE_W,
  parameter CNT_W    = `FFMT_CNT_W
) (
  input  wire                    clk_sys_in,
  input  wire                    resetn_in,
  // byte register port
  input  wire [`FFMT_ADDR_W-1:0] reg_addr_in,
  input  wire                    reg_wr_in,
  input  wire [7:0]              reg_wdata_in,
  input  wire                    reg_rd_in,
  output reg  [7:0]              reg_rdata_out,
  output reg                     reg_hit_out,
  // configuration held outside this block
  input  wire                    event_logic_high_in,
  input  wire [2:0]              axis_enable_in,
  input  wire [CNT_W-1:0]        debounce_count_in,
  // sample stream
  input  wire                    sample_tick_in,
  input  wire [SAMPLE_W-1:0]     x_sample_in,
  input  wire [SAMPLE_W-1:0]     y_sample_in,
  input  wire [SAMPLE_W-1:0]     z_sample_in,
  // results
  output reg                     event_out,
  output reg                     condition_out,
  output reg  [CNT_W-1:0]        debounce_cnt_out,
  output reg  [2:0]              axis_hit_out,
  output reg  [2:0]              axis_negative_out,
  output reg                     per_axis_mode_out,
  output reg                     sharing_conflict_out
);

  localparam THS_W = `FFMT_AXIS_THS_W;

  // register storage
  reg  [7:0]       shared_ths_r;
  reg  [7:0]       x_high_r;
  reg  [7:0]       x_low_r;
  reg  [7:0]       y_high_r;
  reg  [7:0]       y_low_r;
  reg  [7:0]       z_high_r;
  reg  [7:0]       z_low_r;
  reg  [CNT_W-1:0] dbc_r;

  reg  [CNT_W-1:0] dbc_nxt;
  reg  [7:0]       rdata_nxt;
  reg              hit_nxt;
  reg              cond_nxt;

  wire             clear_mode;
  wire             per_axis_en;
  wire             trans_share_en;
  wire [THS_W-1:0] shared_ths_wide;
  wire [THS_W-1:0] x_ths;
  wire [THS_W-1:0] y_ths;
  wire [THS_W-1:0] z_ths;
  wire [THS_W-1:0] x_used;
  wire [THS_W-1:0] y_used;
  wire [THS_W-1:0] z_used;
  wire [2:0]       above;
  wire [2:0]       below;
  wire [2:0]       negative;
  wire             low_g_cond;
  wire             high_g_cond;

  // register writes; a write to the shared register leaves a running count alone

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      shared_ths_r <= `FFMT_RST_BYTE;
      x_high_r     <= `FFMT_RST_BYTE;
      x_low_r      <= `FFMT_RST_BYTE;
      y_high_r     <= `FFMT_RST_BYTE;
      y_low_r      <= `FFMT_RST_BYTE;
      z_high_r     <= `FFMT_RST_BYTE;
      z_low_r      <= `FFMT_RST_BYTE;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `FFMT_OFS_SHARED_THS: shared_ths_r <= reg_wdata_in;
        `FFMT_OFS_X_THS_HIGH: x_high_r     <= reg_wdata_in;
        `FFMT_OFS_X_THS_LOW:  x_low_r      <= reg_wdata_in;
        `FFMT_OFS_Y_THS_HIGH: y_high_r     <= reg_wdata_in;
        `FFMT_OFS_Y_THS_LOW:  y_low_r      <= reg_wdata_in;
        `FFMT_OFS_Z_THS_HIGH: z_high_r     <= reg_wdata_in;
        `FFMT_OFS_Z_THS_LOW:  z_low_r      <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // register reads, one cycle after the strobe; every bit reads back as written
  always @* begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b1;
    case (reg_addr_in)
      `FFMT_OFS_SHARED_THS: rdata_nxt = shared_ths_r;
      `FFMT_OFS_X_THS_HIGH: rdata_nxt = x_high_r;
      `FFMT_OFS_X_THS_LOW:  rdata_nxt = x_low_r;
      `FFMT_OFS_Y_THS_HIGH: rdata_nxt = y_high_r;
      `FFMT_OFS_Y_THS_LOW:  rdata_nxt = y_low_r;
      `FFMT_OFS_Z_THS_HIGH: rdata_nxt = z_high_r;
      `FFMT_OFS_Z_THS_LOW:  rdata_nxt = z_low_r;
      default:              hit_nxt   = 1'b0;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
      reg_hit_out   <= 1'b0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
      reg_hit_out   <= hit_nxt;
    end else begin
      reg_hit_out   <= 1'b0;
    end
  end

  // field decode
  assign clear_mode     = shared_ths_r[`FFMT_DBCNT_MODE_BIT];
  assign per_axis_en    = x_high_r[`FFMT_XYZ_EN_BIT];
  assign trans_share_en = y_high_r[`FFMT_TRANS_EN_BIT];

  // shared threshold zero-extended so all axes use one comparator width
  assign shared_ths_wide = {`FFMT_SHARED_PAD,
                            shared_ths_r[`FFMT_SHARED_THS_MSB:`FFMT_SHARED_THS_LSB]};

  // high bits 12..6 above low bits 5..0
  assign x_ths = {x_high_r[`FFMT_HIGH_THS_MSB:0], x_low_r[`FFMT_LOW_THS_MSB:0]};
  assign y_ths = {y_high_r[`FFMT_HIGH_THS_MSB:0], y_low_r[`FFMT_LOW_THS_MSB:0]};
  assign z_ths = {z_high_r[`FFMT_HIGH_THS_MSB:0], z_low_r[`FFMT_LOW_THS_MSB:0]};

  // threshold selection
  assign x_used = per_axis_en ? x_ths : shared_ths_wide;
  assign y_used = per_axis_en ? y_ths : shared_ths_wide;
  assign z_used = per_axis_en ? z_ths : shared_ths_wide;

  axis_threshold_compare #(
    .SAMPLE_W     (SAMPLE_W),
    .THS_W        (THS_W)
  ) u_cmp_x (
    .sample_in    (x_sample_in),
    .threshold_in (x_used),
    .above_out    (above[0]),
    .below_out    (below[0]),
    .negative_out (negative[0])
  );

  axis_threshold_compare #(
    .SAMPLE_W     (SAMPLE_W),
    .THS_W        (THS_W)
  ) u_cmp_y (
    .sample_in    (y_sample_in),
    .threshold_in (y_used),
    .above_out    (above[1]),
    .below_out    (below[1]),
    .negative_out (negative[1])
  );

  axis_threshold_compare #(
    .SAMPLE_W     (SAMPLE_W),
    .THS_W        (THS_W)
  ) u_cmp_z (
    .sample_in    (z_sample_in),
    .threshold_in (z_used),
    .above_out    (above[2]),
    .below_out    (below[2]),
    .negative_out (negative[2])
  );

  // a disabled axis never blocks low-g; with no axis enabled nothing fires
  assign low_g_cond  = (|axis_enable_in) &&
                       (((below | ~axis_enable_in) & 3'b111) == 3'b111);
  assign high_g_cond = |(above & axis_enable_in);

  always @* begin
    cond_nxt = event_logic_high_in ? high_g_cond : low_g_cond;
  end

  // debounce; clear mode ignores which threshold set is active
  always @* begin
    dbc_nxt = dbc_r;
    if (sample_tick_in) begin
      if (cond_nxt) begin
        if (dbc_r < debounce_count_in) begin
          dbc_nxt = dbc_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
          // a lowered count pulls the counter down to it at once
          dbc_nxt = debounce_count_in;
        end
      end else if (clear_mode) begin
        dbc_nxt = {CNT_W{1'b0}};
      end else if (dbc_r != {CNT_W{1'b0}}) begin
        dbc_nxt = dbc_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      dbc_r             <= `FFMT_RST_CNT;
      debounce_cnt_out  <= `FFMT_RST_CNT;
      event_out         <= 1'b0;
      condition_out     <= 1'b0;
      axis_hit_out      <= 3'b000;
      axis_negative_out <= 3'b000;
    end else begin
      dbc_r            <= dbc_nxt;
      debounce_cnt_out <= dbc_nxt;
      if (sample_tick_in) begin
        condition_out     <= cond_nxt;
        // flag follows the counter: it drops once the condition lapses
        event_out         <= cond_nxt && (dbc_nxt == debounce_count_in);
        axis_hit_out      <= event_logic_high_in ? (above & axis_enable_in)
                                                 : (below & axis_enable_in);
        axis_negative_out <= negative & axis_enable_in;
      end
    end
  end

  // status copies of the mode bits; conflict is software's fault, only reported
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      per_axis_mode_out    <= 1'b0;
      sharing_conflict_out <= 1'b0;
    end else begin
      per_axis_mode_out    <= per_axis_en;
      sharing_conflict_out <= per_axis_en && trans_share_en;
    end
  end

endmodule // freefall_motion_threshold_detect

`default_nettype wire

// file: logic/ffmt_regs.vh
// register offsets, field positions, reset values and sizes of the
// freefall/motion threshold block.
// included by the design files by bare name; definitions only.
`ifndef FFMT_REGS_VH
`define FFMT_REGS_VH

// register offsets on the byte-wide register port
`define FFMT_ADDR_W            7
`define FFMT_OFS_SHARED_THS    7'h17
`define FFMT_OFS_X_THS_HIGH    7'h73
`define FFMT_OFS_X_THS_LOW     7'h74
`define FFMT_OFS_Y_THS_HIGH    7'h75
`define FFMT_OFS_Y_THS_LOW     7'h76
`define FFMT_OFS_Z_THS_HIGH    7'h77
`define FFMT_OFS_Z_THS_LOW     7'h78

// reset values
`define FFMT_RST_BYTE          8'h00
`define FFMT_RST_CNT           8'h00

// field positions
`define FFMT_DBCNT_MODE_BIT    7
`define FFMT_SHARED_THS_MSB    6
`define FFMT_SHARED_THS_LSB    0
`define FFMT_XYZ_EN_BIT        7
`define FFMT_TRANS_EN_BIT      7
`define FFMT_HIGH_THS_MSB      6
`define FFMT_LOW_THS_MSB       5

// sizes
`define FFMT_SHARED_THS_W      7
`define FFMT_AXIS_THS_W        13
`define FFMT_SAMPLE_W          14
`define FFMT_CNT_W             8
`define FFMT_SHARED_PAD        6'h00

`endif

// file: logic/axis_threshold_compare.v
// one axis: absolute value of a signed sample compared with a threshold.
// assumes the sample and threshold are held stable around the sample tick.
`timescale 1ns/1ns
`default_nettype none
`include "ffmt_regs.vh"

module axis_threshold_compare #(
  parameter SAMPLE_W = `FFMT_SAMPLE_W,
  parameter THS_W    = `FFMT_AXIS_THS_W
) (
  input  wire [SAMPLE_W-1:0] sample_in,
  input  wire [THS_W-1:0]    threshold_in,
  output wire                above_out,
  output wire                below_out,
  output wire                negative_out
);

  wire [SAMPLE_W-1:0] negated;
  wire [SAMPLE_W-1:0] magnitude;
  wire [THS_W-1:0]    mag_clip;

  assign negated      = (~sample_in) + {{(SAMPLE_W-1){1'b0}}, 1'b1};
  assign negative_out = sample_in[SAMPLE_W-1];
  assign magnitude    = negative_out ? negated : sample_in;
  // most negative sample saturates instead of wrapping back to zero
  assign mag_clip     = magnitude[SAMPLE_W-1] ? {THS_W{1'b1}} : magnitude[THS_W-1:0];
  assign above_out    = mag_clip > threshold_in;
  assign below_out    = mag_clip < threshold_in;

endmodule // axis_threshold_compare

`default_nettype wire

// file: tb/ffmt_sva.sv
// checker for the freefall/motion threshold block, bound to its ports.
// assumes one clock, synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "ffmt_regs.vh"
module ffmt_sva #(parameter CNT_W = 8) (
  input wire logic             clk_sys_in,
  input wire logic             resetn_in,
  input wire logic [6:0]       reg_addr_in,
  input wire logic             reg_wr_in,
  input wire logic [7:0]       reg_wdata_in,
  input wire logic             reg_rd_in,
  input wire logic [7:0]       reg_rdata_out,
  input wire logic             reg_hit_out,
  input wire logic             event_logic_high_in,
  input wire logic [2:0]       axis_enable_in,
  input wire logic [CNT_W-1:0] debounce_count_in,
  input wire logic             sample_tick_in,
  input wire logic             event_out,
  input wire logic             condition_out,
  input wire logic [CNT_W-1:0] debounce_cnt_out,
  input wire logic [2:0]       axis_hit_out,
  input wire logic             per_axis_mode_out,
  input wire logic             sharing_conflict_out
);
  logic mode_r, xen_r, yen_r;
  wire  conf = xen_r & yen_r;
  wire  mapped = reg_addr_in == 7'h17 || (reg_addr_in >= 7'h73 && reg_addr_in <= 7'h78);
  // shadows of the mode and enable bits, needed to judge the counter, the mode copy and the conflict flag
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      mode_r <= 1'b0;
      xen_r  <= 1'b0;
      yen_r  <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `FFMT_OFS_SHARED_THS) mode_r <= reg_wdata_in[7];
      if (reg_addr_in == `FFMT_OFS_X_THS_HIGH) xen_r <= reg_wdata_in[7];
      if (reg_addr_in == `FFMT_OFS_Y_THS_HIGH) yen_r <= reg_wdata_in[7];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  read_hit_a: assert property (reg_rd_in && mapped |=> reg_hit_out) else $error("no hit");
  unmapped_read_a: assert property (reg_rd_in && !mapped |=> !reg_hit_out && reg_rdata_out == 8'h00)
    else $error("unmapped read answered");
  hold_no_tick_a: assert property (!sample_tick_in |=> $stable(event_out) && $stable(condition_out)
    && $stable(debounce_cnt_out)) else $error("changed without tick");
  clear_mode_a: assert property (sample_tick_in && mode_r ##1 !condition_out |->
    debounce_cnt_out == 0) else $error("counter not cleared");
  decrement_a: assert property (sample_tick_in && !mode_r ##1 !condition_out |->
    debounce_cnt_out == ($past(debounce_cnt_out) == 0 ? 0 : $past(debounce_cnt_out) - 1'b1))
    else $error("counter not decremented");
  count_up_a: assert property (sample_tick_in ##1 condition_out |-> debounce_cnt_out ==
    ($past(debounce_cnt_out) < $past(debounce_count_in) ? $past(debounce_cnt_out) + 1'b1
    : $past(debounce_count_in))) else $error("counter not advanced");
  event_flag_a: assert property (sample_tick_in |=> event_out ==
    (condition_out && debounce_cnt_out == $past(debounce_count_in))) else $error("bad event");
  lowg_none_a: assert property (sample_tick_in && !event_logic_high_in && axis_enable_in == 3'h0
    |=> !condition_out) else $error("low-g with no axis");
  cond_hits_a: assert property (sample_tick_in |=> condition_out == ($past(event_logic_high_in)
    ? |axis_hit_out : (axis_hit_out == $past(axis_enable_in) && $past(axis_enable_in) != 3'h0)))
    else $error("condition disagrees with hits");
  hit_enabled_a: assert property (sample_tick_in |=> (axis_hit_out & ~$past(axis_enable_in)) == 3'h0)
    else $error("disabled axis hit");
  per_axis_a: assert property (per_axis_mode_out == $past(xen_r)) else $error("bad mode copy");
  conflict_a: assert property (sharing_conflict_out == $past(conf)) else $error("bad conflict");
endmodule // ffmt_sva
bind freefall_motion_threshold_detect ffmt_sva #(.CNT_W(CNT_W)) u_ffmt_sva (.*);
`default_nettype wire

// file: tb/freefall_motion_threshold_detect_tb_top.sv
// random self-checking bench for the freefall/motion threshold block.
// assumes the checker is bound from its own file.
`timescale 1ns/1ns
`default_nettype none
module freefall_motion_threshold_detect_tb_top;
  logic        clk_sys_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic        event_logic_high_in = 0, sample_tick_in = 0, el;
  logic [6:0]  reg_addr_in = 0;
  logic [7:0]  reg_wdata_in = 0, debounce_count_in = 0, dc, cnt = 0;
  logic [2:0]  axis_enable_in = 0, en;
  logic [13:0] x_sample_in = 0, y_sample_in = 0, z_sample_in = 0;
  logic [7:0]  r [0:6];
  wire  [7:0]  reg_rdata_out, debounce_cnt_out;
  wire         reg_hit_out, event_out, condition_out, per_axis_mode_out, sharing_conflict_out;
  wire  [2:0]  axis_hit_out, axis_negative_out;
  int          mismatches = 0, cmp_count = 0, cyc = 0;
  freefall_motion_threshold_detect DUT (.*);
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (++cyc == 6000) begin
    mismatches++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [6:0] ad(input int i);
    return (i == 0) ? 7'h17 : 7'(7'h72 + i);
  endfunction
  task automatic wr(input int i, input logic [7:0] d);
    r[i] = d;
    @(posedge clk_sys_in);
    reg_addr_in <= ad(i);
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, e);
    check(reg_hit_out, h);
  endtask
  // magnitude clipped to 13 bits, so the most negative sample reads as full scale
  function automatic logic hit(input logic [13:0] s, input int i);
    logic [12:0] m, t;
    m = s[13] ? ((s == 14'h2000) ? 13'h1FFF : 13'(-s)) : s[12:0];
    t = r[1][7] ? {r[2*i+1][6:0], r[2*i+2][5:0]} : {6'h00, r[0][6:0]};
    return el ? (m > t) : (m < t);
  endfunction
  function automatic logic [13:0] sm;
    return ($urandom_range(0, 15) == 0) ? 14'h2000 : 14'($urandom_range(0, 520)) - 14'h104;
  endfunction
  task automatic tick(input logic [13:0] x, y, z);
    logic [2:0] h;
    logic c;
    h = {hit(z, 2), hit(y, 1), hit(x, 0)} & en;
    c = el ? |h : (en != 3'h0 && h == en);
    if (c) cnt = (cnt < dc) ? cnt + 8'h01 : dc;
    else cnt = (r[0][7] || cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
    @(posedge clk_sys_in);
    {x_sample_in, y_sample_in, z_sample_in} <= {x, y, z};
    {event_logic_high_in, axis_enable_in, debounce_count_in} <= {el, en, dc};
    sample_tick_in <= 1'b1;
    @(posedge clk_sys_in);
    sample_tick_in <= 1'b0;
    #1;
    check(condition_out, c);
    check(axis_hit_out, h);
    check(debounce_cnt_out, cnt);
    check(event_out, c && cnt == dc);
    check(axis_negative_out, {z[13], y[13], x[13]} & en);
  endtask
  initial begin
    void'($urandom(32'h1FC2));
    for (int i = 0; i < 7; i++) r[i] = 8'h00;
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ad(i), 8'h00, 1'b1);
    wr(1, 8'h80);
    wr(3, 8'h80);
    rd(7'h10, 8'h00, 1'b0);
    check(sharing_conflict_out, 1'b1);
    check(per_axis_mode_out, 1'b1);
    wr(3, 8'h00);
    repeat (40) begin
      for (int i = 0; i < 7; i++) wr(i, 8'($urandom) & ((i % 2 == 0) ? 8'hFF : (i == 1) ? 8'h83 : 8'h03));
      for (int i = 0; i < 7; i++) rd(ad(i), r[i], 1'b1);
      el = 1'($urandom);
      en = 3'($urandom);
      dc = 8'($urandom_range(0, 4));
      repeat (12) tick(sm(), sm(), sm());
    end
    report_and_stop();
  end
endmodule // freefall_motion_threshold_detect_tb_top
`default_nettype wire
